// ===== common/vidm_defs.vh
// Offsets, field positions, reset values and timing counts of the voltage-ID monitor
`ifndef VIDM_DEFS_VH
`define VIDM_DEFS_VH

// Register offsets
`define VIDM_ADDR_RES_2V5 8'h20
`define VIDM_ADDR_RES_CORE 8'h21
`define VIDM_ADDR_RES_SUPPLY 8'h22
`define VIDM_ADDR_RES_5V 8'h23
`define VIDM_ADDR_RES_12V 8'h24
`define VIDM_ADDR_CONFIG_FIRST 8'h40
`define VIDM_ADDR_STATUS_SECOND 8'h42
`define VIDM_ADDR_VOLTAGE_ID 8'h43
`define VIDM_ADDR_LIM_12V_LOW 8'h4C
`define VIDM_ADDR_LIM_12V_HIGH 8'h4D
`define VIDM_ADDR_FAN_ONE_MIN_HIGH 8'h55
`define VIDM_ADDR_ADC_CONFIG_SECOND 8'h73
`define VIDM_ADDR_INT_MASK_SECOND 8'h75

// Field positions
`define VIDM_BIT_SIXTH_VID 5
`define VIDM_BIT_THRESHOLD 6
`define VIDM_BIT_PIN_SELECT 7
`define VIDM_BIT_FLAG 0
`define VIDM_BIT_MASK_FLAG 0
`define VIDM_BIT_AVG_OFF 4
`define VIDM_BIT_ATTEN_BYPASS 5
`define VIDM_BIT_SINGLE_CHAN 6
`define VIDM_BIT_VCC_5V 7
`define VIDM_CHAN_SEL_HI 7
`define VIDM_CHAN_SEL_LO 5

// Channel codes
`define VIDM_CHAN_2V5 3'h0
`define VIDM_CHAN_CORE 3'h1
`define VIDM_CHAN_SUPPLY 3'h2
`define VIDM_CHAN_5V 3'h3
`define VIDM_CHAN_12V 3'h4
`define VIDM_NUM_CHAN 5

// Reset values
`define VIDM_RST_BYTE 8'h00
`define VIDM_RST_LIM_LOW 8'h00
`define VIDM_RST_LIM_HIGH 8'hFF
`define VIDM_RST_CODE 10'h000

// Timing
`define VIDM_CLK_PERIOD_NS 100
`define VIDM_CONV_TIME_NS 711000
`define VIDM_CHANGE_WINDOW_NS 11000
`define VIDM_CONV_CYCLES (`VIDM_CONV_TIME_NS / `VIDM_CLK_PERIOD_NS)
`define VIDM_CHANGE_CYCLES (`VIDM_CHANGE_WINDOW_NS / `VIDM_CLK_PERIOD_NS)
`define VIDM_AVG_COUNT 16

`endif

// ===== src/vidm_pin_sync.v
// Three-stage synchroniser for the voltage-ID pins with agreement filter
`timescale 1ns/10ps
`default_nettype none

module vidm_pin_sync (
    input wire clk_sys,
    input wire reset_n,
    input wire [5:0] pin_async,
    output reg [5:0] pin_level
);

    reg [5:0] stage1_r;
    reg [5:0] stage2_r;
    reg [5:0] stage3_r;

    // Stage one feeds only stage two to keep metastability contained
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stage1_r <= 6'h00;
            stage2_r <= 6'h00;
            stage3_r <= 6'h00;
            pin_level <= 6'h00;
        end else begin
            stage1_r <= pin_async;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            pin_level <= (stage2_r & stage3_r) | (pin_level & (stage2_r ^ stage3_r));
        end
    end

endmodule // vidm_pin_sync

`default_nettype wire

// ===== src/vidm_monitor.v
// Voltage-ID monitor with code-change detect and voltage ADC conversion control
`timescale 1ns/10ps
`default_nettype none
`include "vidm_defs.vh"

module vidm_monitor #(
    parameter CONV_CYCLES = `VIDM_CONV_CYCLES
) (
    input wire clk_sys,
    input wire reset_n,
    // Processor voltage-ID pins, asynchronous to clk_sys
    input wire [4:0] voltage_id,
    input wire sixth_voltage_id_input,
    // Register port, strobes one cycle long
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata_r,
    // Converter and analog front end
    input wire [9:0] adc_code,
    output reg [2:0] adc_channel_r,
    output reg adc_sample_r,
    output reg input_threshold_select_r,
    output reg shared_pin_function_select_r,
    output reg attenuator_bypass_r,
    output reg supply_5v_scaling_r,
    output reg smbalert_n_r
);

    // End points worked out at full width, then cut to the counter widths
    localparam integer CONV_LAST_I = CONV_CYCLES - 1;
    localparam integer CHANGE_LAST_I = `VIDM_CHANGE_CYCLES - 1;
    localparam integer AVG_LAST_I = `VIDM_AVG_COUNT - 1;
    localparam [12:0] CONV_LAST = CONV_LAST_I[12:0];
    localparam [6:0] CHANGE_LAST = CHANGE_LAST_I[6:0];
    localparam [3:0] AVG_LAST = AVG_LAST_I[3:0];

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_CONVERT = 2'h1;
    localparam [1:0] ST_STORE = 2'h2;

    wire [5:0] pin_level;
    wire [5:0] vid_live;

    // Software-visible registers
    reg [7:0] config_first_r;
    reg [1:0] vid_ctrl_r;
    reg [7:0] lim_low_r;
    reg [7:0] lim_high_r;
    reg [7:0] fan_one_min_high_r;
    reg [7:0] adc_config_r;
    reg [7:0] int_mask_r;

    reg [5:0] vid_prev_r;
    reg [6:0] change_cnt_r;
    reg change_flag_r;
    reg limit_flag_r;

    // Conversion sequencer and result hand-over
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [12:0] conv_cnt_r;
    reg [3:0] avg_cnt_r;
    reg [13:0] acc_r;
    reg [2:0] chan_r;
    reg store_r;
    reg [9:0] store_code_r;
    reg [2:0] store_chan_r;

    wire [9:0] result_code [0:`VIDM_NUM_CHAN-1];

    wire pin_is_vid = vid_ctrl_r[1];
    wire avg_off = adc_config_r[`VIDM_BIT_AVG_OFF];
    wire single_mode = adc_config_r[`VIDM_BIT_SINGLE_CHAN];
    wire [2:0] chan_sel = fan_one_min_high_r[`VIDM_CHAN_SEL_HI:`VIDM_CHAN_SEL_LO];
    wire status_bit0 = pin_is_vid ? change_flag_r : limit_flag_r;
    wire status_read = reg_read && (reg_addr == `VIDM_ADDR_STATUS_SECOND);
    // Bit 5 is watched only in sixth-input mode, so a mode switch is no code change
    wire [5:0] vid_watch = {pin_is_vid, 5'h1F};
    wire vid_changed = |((pin_level ^ vid_prev_r) & vid_watch);
    wire [7:0] store_byte = store_code_r[9:2];
    wire limit_hit = (store_byte > lim_high_r) || (store_byte < lim_low_r);
    // Mask gates the 12 V source too, so one bit silences the alert in either mode
    wire alert_cause = status_bit0 && !int_mask_r[`VIDM_BIT_MASK_FLAG];

    // Three stages plus agreement filter: four edges from pin to register
    vidm_pin_sync u_pin_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pin_async({sixth_voltage_id_input, voltage_id}),
        .pin_level(pin_level)
    );

    // Shared pin carries an analog level in 12 V mode, so its bit is forced low
    assign vid_live = {pin_level[5] & pin_is_vid, pin_level[4:0]};

    // Register writes
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            config_first_r <= `VIDM_RST_BYTE;
            vid_ctrl_r <= 2'h0;
            lim_low_r <= `VIDM_RST_LIM_LOW;
            lim_high_r <= `VIDM_RST_LIM_HIGH;
            fan_one_min_high_r <= `VIDM_RST_BYTE;
            adc_config_r <= `VIDM_RST_BYTE;
            int_mask_r <= `VIDM_RST_BYTE;
        end else if (reg_write) begin
            case (reg_addr)
                `VIDM_ADDR_CONFIG_FIRST: begin
                    config_first_r <= reg_wdata;
                end
                `VIDM_ADDR_VOLTAGE_ID: begin
                    vid_ctrl_r <= reg_wdata[`VIDM_BIT_PIN_SELECT:`VIDM_BIT_THRESHOLD];
                end
                `VIDM_ADDR_LIM_12V_LOW: begin
                    lim_low_r <= reg_wdata;
                end
                `VIDM_ADDR_LIM_12V_HIGH: begin
                    lim_high_r <= reg_wdata;
                end
                `VIDM_ADDR_FAN_ONE_MIN_HIGH: begin
                    fan_one_min_high_r <= reg_wdata;
                end
                `VIDM_ADDR_ADC_CONFIG_SECOND: begin
                    adc_config_r <= reg_wdata;
                end
                `VIDM_ADDR_INT_MASK_SECOND: begin
                    int_mask_r <= reg_wdata;
                end
                default: begin
                    config_first_r <= config_first_r;
                end
            endcase
        end
    end

    // Register reads, data one cycle after the strobe
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `VIDM_ADDR_RES_2V5: reg_rdata_r <= result_code[0][9:2];
                `VIDM_ADDR_RES_CORE: reg_rdata_r <= result_code[1][9:2];
                `VIDM_ADDR_RES_SUPPLY: reg_rdata_r <= result_code[2][9:2];
                `VIDM_ADDR_RES_5V: reg_rdata_r <= result_code[3][9:2];
                `VIDM_ADDR_RES_12V: reg_rdata_r <= result_code[4][9:2];
                `VIDM_ADDR_CONFIG_FIRST: reg_rdata_r <= config_first_r;
                `VIDM_ADDR_STATUS_SECOND: reg_rdata_r <= {7'h00, status_bit0};
                `VIDM_ADDR_VOLTAGE_ID: reg_rdata_r <= {vid_ctrl_r, vid_live};
                `VIDM_ADDR_LIM_12V_LOW: reg_rdata_r <= lim_low_r;
                `VIDM_ADDR_LIM_12V_HIGH: reg_rdata_r <= lim_high_r;
                `VIDM_ADDR_FAN_ONE_MIN_HIGH: reg_rdata_r <= fan_one_min_high_r;
                `VIDM_ADDR_ADC_CONFIG_SECOND: reg_rdata_r <= adc_config_r;
                `VIDM_ADDR_INT_MASK_SECOND: reg_rdata_r <= int_mask_r;
                default: reg_rdata_r <= 8'h00;
            endcase
        end
    end

    // Change detect: flag stays up for the whole window after the last edge
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            vid_prev_r <= 6'h00;
            change_cnt_r <= 7'h00;
            change_flag_r <= 1'b0;
        end else begin
            vid_prev_r <= pin_level;
            // Flag means nothing in 12 V mode, so it is held clear there
            if (!pin_is_vid) begin
                change_cnt_r <= 7'h00;
                change_flag_r <= 1'b0;
            end else if (vid_changed) begin
                change_cnt_r <= CHANGE_LAST;
                change_flag_r <= 1'b1;
            end else if (change_cnt_r != 7'h00) begin
                change_cnt_r <= change_cnt_r - 7'h01;
            end else begin
                change_flag_r <= 1'b0;
            end
        end
    end

    // Sticky 12 V limit flag, cleared by a status read; a new fault wins over the clear
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            limit_flag_r <= 1'b0;
        end else if (store_r && (store_chan_r == `VIDM_CHAN_12V) && !pin_is_vid && limit_hit) begin
            limit_flag_r <= 1'b1;
        end else if (status_read || pin_is_vid) begin
            limit_flag_r <= 1'b0;
        end
    end

    // Alert line follows the selected status source gated by its mask
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            smbalert_n_r <= 1'b1;
        end else begin
            smbalert_n_r <= !alert_cause;
        end
    end

    // Analog front-end controls
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            input_threshold_select_r <= 1'b0;
            shared_pin_function_select_r <= 1'b0;
            attenuator_bypass_r <= 1'b0;
            supply_5v_scaling_r <= 1'b0;
        end else begin
            input_threshold_select_r <= vid_ctrl_r[0];
            shared_pin_function_select_r <= pin_is_vid;
            attenuator_bypass_r <= adc_config_r[`VIDM_BIT_ATTEN_BYPASS];
            supply_5v_scaling_r <= config_first_r[`VIDM_BIT_VCC_5V];
        end
    end

    // Conversion sequencer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                state_nxt = ST_CONVERT;
            end
            ST_CONVERT: begin
                if (conv_cnt_r == CONV_LAST && (avg_off || avg_cnt_r == AVG_LAST)) begin
                    state_nxt = ST_STORE;
                end
            end
            ST_STORE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Next channel: fixed in single mode, otherwise round robin skipping 12 V when it is a pin
    function [2:0] next_chan;
        input [2:0] cur;
        input single;
        input [2:0] sel;
        input skip_12v;
        begin
            if (single) begin
                next_chan = (sel > `VIDM_CHAN_12V) ? `VIDM_CHAN_2V5 : sel;
            end else if (cur >= `VIDM_CHAN_12V ||
                         (skip_12v && cur == `VIDM_CHAN_5V)) begin
                next_chan = `VIDM_CHAN_2V5;
            end else begin
                next_chan = cur + 3'h1;
            end
        end
    endfunction

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            conv_cnt_r <= 13'h0000;
            avg_cnt_r <= 4'h0;
            acc_r <= 14'h0000;
            chan_r <= `VIDM_CHAN_2V5;
            adc_channel_r <= `VIDM_CHAN_2V5;
            adc_sample_r <= 1'b0;
            store_r <= 1'b0;
            store_code_r <= `VIDM_RST_CODE;
            store_chan_r <= `VIDM_CHAN_2V5;
        end else begin
            state_r <= state_nxt;
            adc_sample_r <= 1'b0;
            store_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    // One idle cycle lets the converter see the new channel first
                    conv_cnt_r <= 13'h0000;
                    avg_cnt_r <= 4'h0;
                    acc_r <= 14'h0000;
                    adc_channel_r <= chan_r;
                end
                ST_CONVERT: begin
                    if (conv_cnt_r == CONV_LAST) begin
                        conv_cnt_r <= 13'h0000;
                        adc_sample_r <= 1'b1;
                        acc_r <= acc_r + {4'h0, adc_code};
                        avg_cnt_r <= avg_cnt_r + 4'h1;
                    end else begin
                        conv_cnt_r <= conv_cnt_r + 13'h0001;
                    end
                end
                ST_STORE: begin
                    store_r <= 1'b1;
                    store_chan_r <= chan_r;
                    // Single conversion keeps full resolution of the last sample
                    store_code_r <= avg_off ? acc_r[9:0] : acc_r[13:4];
                    chan_r <= next_chan(chan_r, single_mode, chan_sel, pin_is_vid);
                end
                default: begin
                    conv_cnt_r <= 13'h0000;
                end
            endcase
        end
    end

    // Result registers, one per channel
    genvar gi;
    generate
        for (gi = 0; gi < `VIDM_NUM_CHAN; gi = gi + 1) begin : g_result
            reg [9:0] code_r;
            always @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    code_r <= `VIDM_RST_CODE;
                end else if (store_r && {29'h0, store_chan_r} == gi) begin
                    code_r <= store_code_r;
                end
            end
            assign result_code[gi] = code_r;
        end
    endgenerate

endmodule // vidm_monitor

`default_nettype wire

// ===== testbench/vidm_partner.sv
// Processor voltage-ID pins and ADC front end seen by the monitor
`timescale 1ns/10ps
`default_nettype none
module vidm_partner (
    input wire logic clk_sys,
    input wire logic [5:0] vid_set,
    input wire logic [2:0] adc_channel_r,
    input wire logic adc_sample_r,
    output logic [4:0] voltage_id,
    output logic sixth_voltage_id_input,
    output logic [9:0] adc_code
);
    logic alt = 1'b0;
    assign {sixth_voltage_id_input, voltage_id} = vid_set;
    // Codes alternate by 16 so an averaged result differs from a single one
    assign adc_code = 10'h100 + {1'b0, adc_channel_r, 6'h00} + {5'h00, alt, 4'h0};
    always @(posedge clk_sys) begin
        if (adc_sample_r) begin
            alt <= ~alt;
        end
    end
endmodule // vidm_partner
`default_nettype wire

// ===== testbench/vidm_monitor_sva.sv
// Port-level checks of the voltage-ID monitor
`timescale 1ns/10ps
`default_nettype none
module vidm_monitor_sva #(
    parameter int CONV_CYCLES = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [4:0] voltage_id,
    input wire logic sixth_voltage_id_input,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata_r,
    input wire logic [2:0] adc_channel_r,
    input wire logic adc_sample_r,
    input wire logic input_threshold_select_r,
    input wire logic shared_pin_function_select_r,
    input wire logic attenuator_bypass_r,
    input wire logic supply_5v_scaling_r
);
    logic [3:0] stab_r;
    logic [15:0] gap_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Pin age, so reads are judged only once the synchroniser has settled
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stab_r <= 4'h0;
            gap_r <= 16'(CONV_CYCLES);
        end else begin
            if (!$stable({sixth_voltage_id_input, voltage_id})) begin
                stab_r <= 4'h0;
            end else if (stab_r != 4'hF) begin
                stab_r <= stab_r + 4'h1;
            end
            if (adc_sample_r) begin
                gap_r <= 16'h0001;
            end else if (gap_r != 16'hFFFF) begin
                gap_r <= gap_r + 16'h0001;
            end
        end
    end
    thr_write_a: assert property (
        reg_write && reg_addr == 8'h43 |=> ##1
        input_threshold_select_r == $past(reg_wdata[6], 2))
        else $error("threshold select not taken");
    pin_sel_a: assert property (
        reg_write && reg_addr == 8'h43 |=> ##1
        shared_pin_function_select_r == $past(reg_wdata[7], 2))
        else $error("pin function not taken");
    sel_read_a: assert property (
        reg_read && !reg_write && reg_addr == 8'h43 |=> reg_rdata_r[7] == shared_pin_function_select_r)
        else $error("pin function readback wrong");
    bit5_zero_a: assert property (
        reg_read && reg_addr == 8'h43 |=> shared_pin_function_select_r || !reg_rdata_r[5])
        else $error("sixth input bit not zero");
    vid_read_a: assert property (
        reg_read && reg_addr == 8'h43 && stab_r > 4'h6 |=> reg_rdata_r[5:0] ==
        {$past(sixth_voltage_id_input) & shared_pin_function_select_r, $past(voltage_id)})
        else $error("pin levels misread");
    bypass_write_a: assert property (
        reg_write && reg_addr == 8'h73 |=> ##1
        attenuator_bypass_r == $past(reg_wdata[5], 2))
        else $error("bypass not taken");
    scale_write_a: assert property (
        reg_write && reg_addr == 8'h40 |=> ##1
        supply_5v_scaling_r == $past(reg_wdata[7], 2))
        else $error("supply scaling not taken");
    chan_range_a: assert property (adc_channel_r <= 3'h4)
        else $error("channel out of range");
    conv_gap_a: assert property (adc_sample_r |-> gap_r >= 16'(CONV_CYCLES))
        else $error("conversion too short");
endmodule // vidm_monitor_sva

bind vidm_monitor vidm_monitor_sva #(.CONV_CYCLES(CONV_CYCLES)) u_sva (.*);
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the voltage-ID monitor
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int CONV = 8;
    localparam int RES = 16 * CONV + 4;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [5:0] vid_set = 6'h00;
    logic [7:0] reg_rdata_r;
    logic [4:0] voltage_id;
    logic sixth_voltage_id_input;
    logic [9:0] adc_code;
    logic [2:0] adc_channel_r;
    logic adc_sample_r;
    logic input_threshold_select_r;
    logic shared_pin_function_select_r;
    logic attenuator_bypass_r;
    logic supply_5v_scaling_r;
    logic smbalert_n_r;
    int errors = 0;
    int check_count = 0;
    int seed = 32'h149A;
    logic [15:0] exp_q[$];
    logic [15:0] ent;
    logic [5:0] old;

    vidm_monitor #(.CONV_CYCLES(CONV)) dut (.*);
    vidm_partner u_part (.*);

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input logic [7:0] m);
        check_count++;
        if ((seen & m) !== (exp & m)) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk_sys);
        reg_write = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(negedge clk_sys);
        reg_addr = a;
        reg_read = 1'b1;
        exp_q.push_back({m, e});
        @(negedge clk_sys);
        reg_read = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic fin(input string s);
        $display("test %0s finished", s);
    endtask
    function automatic logic [7:0] vexp(input int m, input logic [5:0] x);
        return {m[1:0], x[5] & m[1], x[4:0]};
    endfunction
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Read data settles one edge after the read is taken
    always @(posedge clk_sys) begin
        if (reg_read) begin
            @(negedge clk_sys);
            @(negedge clk_sys);
            ent = exp_q.pop_front();
            check(reg_rdata_r, ent[7:0], ent[15:8]);
        end
    end

    initial begin
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        rd(8'h43, 8'h00, 8'hFF);
        rd(8'h73, 8'h00, 8'hFF);
        rd(8'h55, 8'h00, 8'hFF);
        rd(8'h4D, 8'hFF, 8'hFF);
        rd(8'h10, 8'h00, 8'hFF);
        fin("reset");
        idle(10 * RES);
        for (int c = 0; c < 5; c++) begin
            rd(8'h20 + 8'(c), 8'h42 + 8'(c * 16), 8'hFF);
        end
        rd(8'h42, 8'h00, 8'h01);
        fin("averaging");
        wr(8'h4D, 8'h40);
        idle(5 * RES);
        check({7'h00, smbalert_n_r}, 8'h00, 8'h01);
        wr(8'h4D, 8'hFF);
        rd(8'h42, 8'h01, 8'h01);
        idle(5 * RES);
        rd(8'h4D, 8'hFF, 8'hFF);
        rd(8'h42, 8'h00, 8'h01);
        check({7'h00, smbalert_n_r}, 8'h01, 8'h01);
        fin("limit");
        wr(8'h73, 8'h10);
        idle(5 * RES);
        for (int c = 0; c < 5; c++) begin
            rd(8'h20 + 8'(c), 8'h40 + 8'(c * 16), 8'hFB);
        end
        wr(8'h73, 8'h00);
        fin("single conversion");
        for (int m = 0; m < 4; m++) begin
            wr(8'h43, {m[1:0], 6'h3F});
            idle(1);
            check({6'h00, shared_pin_function_select_r, input_threshold_select_r}, 8'(m), 8'h03);
            for (int k = 0; k < 4; k++) begin
                old = vid_set;
                vid_set = 6'($random(seed));
                rd(8'h43, vexp(m, old), 8'hFF);
                idle(8);
                rd(8'h43, vexp(m, vid_set), 8'hFF);
            end
        end
        fin("pin levels");
        idle(130);
        rd(8'h42, 8'h00, 8'h01);
        check({7'h00, smbalert_n_r}, 8'h01, 8'h01);
        vid_set = vid_set ^ 6'h01;
        idle(8);
        rd(8'h42, 8'h01, 8'h01);
        check({7'h00, smbalert_n_r}, 8'h00, 8'h01);
        idle(85);
        rd(8'h42, 8'h01, 8'h01);
        idle(40);
        rd(8'h42, 8'h00, 8'h01);
        check({7'h00, smbalert_n_r}, 8'h01, 8'h01);
        wr(8'h75, 8'h01);
        vid_set = vid_set ^ 6'h20;
        idle(8);
        check({7'h00, smbalert_n_r}, 8'h01, 8'h01);
        rd(8'h42, 8'h01, 8'h01);
        idle(130);
        wr(8'h75, 8'h00);
        fin("code change");
        wr(8'h43, 8'h00);
        for (int c = 0; c < 5; c++) begin
            wr(8'h73, 8'h60);
            wr(8'h55, {c[2:0], 5'h00});
            wr(8'h40, {c[0], 7'h00});
            idle(2 * RES);
            check({5'h00, adc_channel_r}, 8'(c), 8'h07);
            check({7'h00, attenuator_bypass_r}, 8'h01, 8'h01);
            check({7'h00, supply_5v_scaling_r}, {7'h00, c[0]}, 8'h01);
        end
        wr(8'h55, 8'hE0);
        idle(2 * RES);
        check({5'h00, adc_channel_r}, 8'h00, 8'h07);
        wr(8'h73, 8'h00);
        idle(1);
        check({7'h00, attenuator_bypass_r}, 8'h00, 8'h01);
        fin("channel select");
        print_verdict();
    end

    // About three and a half times the expected run length
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        print_verdict();
    end
endmodule // tb
`default_nettype wire
